// *** rx_status_pkg.sv ***
package rx_status_pkg;

	// ==========================================================
	// Register map (word index, byte address is four times it)
	localparam logic [7:0] CONFIG_INDEX = 8'h12;
	localparam logic [7:0] STATUS_INDEX = 8'h13;

	// ==========================================================
	// Receive configuration fields
	localparam int CRC_ENABLE_BIT  = 0;
	localparam int CRC_INVERT_BIT  = 1;
	localparam int CRC_TYPE_BIT    = 2;
	localparam int MULTI_FRAME_BIT = 3;
	localparam int ALIGN_LSB       = 4;
	localparam int ALIGN_W         = 3;
	localparam int PARITY_STOP_BIT = 7;
	localparam int CONFIG_W        = 8;
	localparam logic [CONFIG_W-1:0] CONFIG_RESET = 8'h00;

	// ==========================================================
	// Receive status fields
	localparam int BYTES_LSB     = 0;
	localparam int BYTES_W       = 9;
	localparam int FRAMES_LSB    = 9;
	localparam int FRAMES_W      = 4;
	localparam int LAST_BITS_LSB = 13;
	localparam int LAST_BITS_W   = 3;
	localparam int INTEGRITY_BIT = 16;
	localparam int PROTOCOL_BIT  = 17;
	localparam int COLLISION_BIT = 18;
	localparam int COLL_POS_LSB  = 19;
	localparam int COLL_POS_W    = 7;

	// ==========================================================
	// CRC constants
	localparam logic [15:0] CRC16_POLY        = 16'h8408;
	localparam logic [15:0] CRC16_PRESET_NORM = 16'h6363;
	localparam logic [15:0] CRC16_PRESET_INV  = 16'hFFFF;
	localparam logic [15:0] CRC16_RESIDUE_INV = 16'hF0B8;
	localparam logic [15:0] CRC16_RESIDUE     = 16'h0000;
	localparam logic [4:0]  CRC5_POLY         = 5'h14;
	localparam logic [4:0]  CRC5_PRESET       = 5'h09;
	localparam logic [4:0]  CRC5_RESIDUE      = 5'h00;

	// ==========================================================
	// Bus responses
	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_DECERR = 2'h3;

	// ==========================================================
	// Mode detector results and receiver states
	typedef enum logic [1:0] {
		MODE_NONE   = 2'h0,
		MODE_TYPE_A = 2'h1,
		MODE_TYPE_B = 2'h2,
		MODE_JIS    = 2'h3
	} mode_t;

	typedef enum logic [1:0] {
		ST_IDLE = 2'h0,
		ST_RECV = 2'h1,
		ST_HALT = 2'h3
	} rx_state_t;

endpackage

// *** crc_check.sv ***
`timescale 1ns/100ps

module crc_check
(
	input  wire logic       clk_in,
	input  wire logic       rst_in,
	input  wire logic       init_in,
	input  wire logic       invert_in,
	input  wire logic       byte_valid_in,
	input  wire logic [7:0] byte_in,
	output logic      [15:0] crc16_out,
	output logic      [4:0]  crc5_out
);

	// ==========================================================
	// Bytewise update, least significant bit first
	function automatic logic [15:0] step16(input logic [15:0] c,
		input logic [7:0] d);
		logic [15:0] r;
		r = c;
		for (int i = 0; i < 8; i++)
		begin
			if (r[0] ^ d[i])
				r = (r >> 1) ^ rx_status_pkg::CRC16_POLY;
			else
				r = r >> 1;
		end
		return r;
	endfunction

	function automatic logic [4:0] step5(input logic [4:0] c,
		input logic [7:0] d);
		logic [4:0] r;
		r = c;
		for (int i = 0; i < 8; i++)
		begin
			if (r[0] ^ d[i])
				r = (r >> 1) ^ rx_status_pkg::CRC5_POLY;
			else
				r = r >> 1;
		end
		return r;
	endfunction

	logic [15:0] next_crc16;
	logic [4:0]  next_crc5;

	always_comb
	begin
		next_crc16 = crc16_out;
		next_crc5  = crc5_out;
		if (init_in)
		begin
			next_crc16 = invert_in ? rx_status_pkg::CRC16_PRESET_INV
				: rx_status_pkg::CRC16_PRESET_NORM;
			next_crc5  = rx_status_pkg::CRC5_PRESET;
		end
		else if (byte_valid_in)
		begin
			next_crc16 = step16(crc16_out, byte_in);
			next_crc5  = step5(crc5_out, byte_in);
		end
	end

	always_ff @(posedge clk_in)
	begin
		if (rst_in)
		begin
			crc16_out <= rx_status_pkg::CRC16_PRESET_NORM;
			crc5_out  <= rx_status_pkg::CRC5_PRESET;
		end
		else
		begin
			crc16_out <= next_crc16;
			crc5_out  <= next_crc5;
		end
	end

endmodule

// *** rx_decoder_crc_status.sv ***
`timescale 1ns/100ps

// Function
// - CRC type: 0 is 16-bit, 1 is 5-bit
// - Invert clear: plain residue; type A/JIS clear
// - Invert set: residue F0B8h; type B sets
// - Enable set checks CRC; default off
// - Type B or JIS sets CRC enable
// - Bits 19-25 hold first collision position
// - Alignment offset added into collision position
// - Bit 18 set on any collision in receive state
// - Bit 17 set on framing or length error
// - Protocol error stops frame data acceptance
// - Error flags clear at next reception start
// - Bit 16 set on parity or CRC mismatch
// - Integrity error keeps reception running
// - Parity stop criterion suppresses parity error
// - Bits 13-15 give valid last-byte bits
// - Bits 9-12 count frames at done event
// - Bits 0-8 byte count, kept until re-enable
module rx_decoder_crc_status
#(
	parameter int ADDR_W = 8
)
(
	input  wire logic              clk_in,
	input  wire logic              rst_in,
	input  wire logic [ADDR_W-1:0] s_axi_awaddr_in,
	input  wire logic              s_axi_awvalid_in,
	output logic                   s_axi_awready_out,
	input  wire logic [31:0]       s_axi_wdata_in,
	input  wire logic [3:0]        s_axi_wstrb_in,
	input  wire logic              s_axi_wvalid_in,
	output logic                   s_axi_wready_out,
	output logic [1:0]             s_axi_bresp_out,
	output logic                   s_axi_bvalid_out,
	input  wire logic              s_axi_bready_in,
	input  wire logic [ADDR_W-1:0] s_axi_araddr_in,
	input  wire logic              s_axi_arvalid_in,
	output logic                   s_axi_arready_out,
	output logic [31:0]            s_axi_rdata_out,
	output logic [1:0]             s_axi_rresp_out,
	output logic                   s_axi_rvalid_out,
	input  wire logic              s_axi_rready_in,
	input  wire logic              mode_detect_valid_in,
	input  wire logic [1:0]        mode_detect_code_in,
	input  wire logic              rx_enable_in,
	input  wire logic              rx_sof_in,
	input  wire logic              rx_byte_valid_in,
	input  wire logic [7:0]        rx_byte_in,
	input  wire logic              rx_parity_error_in,
	input  wire logic              rx_collision_in,
	input  wire logic [2:0]        rx_collision_bit_in,
	input  wire logic              rx_stop_bit_error_in,
	input  wire logic              rx_sof_eof_error_in,
	input  wire logic              rx_length_error_in,
	input  wire logic              rx_end_in,
	input  wire logic [2:0]        rx_last_bits_in,
	output logic                   rx_accept_out,
	output logic                   receive_done_interrupt_out,
	output logic                   collision_position_valid_out,
	output logic                   multi_frame_reception_out
);

	// ==========================================================
	// Address decode
	function automatic logic [1:0] reg_select(input logic [ADDR_W-1:0] a);
		if (a == ADDR_W'({rx_status_pkg::CONFIG_INDEX, 2'b00}))
			return 2'h1;
		else if (a == ADDR_W'({rx_status_pkg::STATUS_INDEX, 2'b00}))
			return 2'h2;
		return 2'h0;
	endfunction

	// ==========================================================
	// Bus channel state
	logic              aw_full, next_aw_full;
	logic [ADDR_W-1:0] aw_addr, next_aw_addr;
	logic              w_full, next_w_full;
	logic [31:0]       w_data, next_w_data;
	logic [3:0]        w_strb, next_w_strb;
	logic              bvalid, next_bvalid;
	logic [1:0]        bresp, next_bresp;
	logic              rvalid, next_rvalid;
	logic [31:0]       rdata, next_rdata;
	logic [1:0]        rresp, next_rresp;
	logic              wr_fire;
	logic [31:0]       status_word;
	logic [rx_status_pkg::CONFIG_W-1:0] config_q, next_config;

	assign s_axi_awready_out = !aw_full && !bvalid;
	assign s_axi_wready_out  = !w_full && !bvalid;
	assign s_axi_arready_out = !rvalid;
	assign s_axi_bvalid_out  = bvalid;
	assign s_axi_bresp_out   = bresp;
	assign s_axi_rvalid_out  = rvalid;
	assign s_axi_rdata_out   = rdata;
	assign s_axi_rresp_out   = rresp;
	assign wr_fire = aw_full && w_full && !bvalid;

	always_comb
	begin
		next_aw_full = aw_full;
		next_aw_addr = aw_addr;
		next_w_full  = w_full;
		next_w_data  = w_data;
		next_w_strb  = w_strb;
		next_bvalid  = bvalid;
		next_bresp   = bresp;
		next_rvalid  = rvalid;
		next_rdata   = rdata;
		next_rresp   = rresp;
		if (s_axi_awvalid_in && s_axi_awready_out)
		begin
			next_aw_full = 1'b1;
			next_aw_addr = s_axi_awaddr_in;
		end
		if (s_axi_wvalid_in && s_axi_wready_out)
		begin
			next_w_full = 1'b1;
			next_w_data = s_axi_wdata_in;
			next_w_strb = s_axi_wstrb_in;
		end
		if (wr_fire)
		begin
			next_aw_full = 1'b0;
			next_w_full  = 1'b0;
			next_bvalid  = 1'b1;
			next_bresp   = (reg_select(aw_addr) == 2'h0)
				? rx_status_pkg::RESP_DECERR : rx_status_pkg::RESP_OKAY;
		end
		if (bvalid && s_axi_bready_in)
			next_bvalid = 1'b0;
		if (s_axi_arvalid_in && s_axi_arready_out)
		begin
			next_rvalid = 1'b1;
			next_rresp  = rx_status_pkg::RESP_OKAY;
			case (reg_select(s_axi_araddr_in))
				2'h1:    next_rdata = 32'(config_q);
				2'h2:    next_rdata = status_word;
				default:
				begin
					next_rdata = 32'h00000000;
					next_rresp = rx_status_pkg::RESP_DECERR;
				end
			endcase
		end
		else if (rvalid && s_axi_rready_in)
			next_rvalid = 1'b0;
	end

	always_ff @(posedge clk_in)
	begin
		if (rst_in)
		begin
			aw_full <= 1'b0;
			aw_addr <= '0;
			w_full  <= 1'b0;
			w_data  <= 32'h00000000;
			w_strb  <= 4'h0;
			bvalid  <= 1'b0;
			bresp   <= rx_status_pkg::RESP_OKAY;
			rvalid  <= 1'b0;
			rdata   <= 32'h00000000;
			rresp   <= rx_status_pkg::RESP_OKAY;
		end
		else
		begin
			aw_full <= next_aw_full;
			aw_addr <= next_aw_addr;
			w_full  <= next_w_full;
			w_data  <= next_w_data;
			w_strb  <= next_w_strb;
			bvalid  <= next_bvalid;
			bresp   <= next_bresp;
			rvalid  <= next_rvalid;
			rdata   <= next_rdata;
			rresp   <= next_rresp;
		end
	end

	// ==========================================================
	// Configuration: host writes, mode detector overrides
	logic crc_enable, crc_invert, crc_type, multi_frame_enable, parity_stop;
	logic [2:0] rx_align;

	assign crc_enable         = config_q[rx_status_pkg::CRC_ENABLE_BIT];
	assign crc_invert         = config_q[rx_status_pkg::CRC_INVERT_BIT];
	assign crc_type           = config_q[rx_status_pkg::CRC_TYPE_BIT];
	assign multi_frame_enable = config_q[rx_status_pkg::MULTI_FRAME_BIT];
	assign parity_stop        = config_q[rx_status_pkg::PARITY_STOP_BIT];
	assign rx_align = config_q[rx_status_pkg::ALIGN_LSB +: 3];
	assign multi_frame_reception_out = multi_frame_enable;

	always_comb
	begin
		next_config = config_q;
		// Status writes are dropped here: only config takes data
		if (wr_fire && reg_select(aw_addr) == 2'h1 && w_strb[0])
			next_config = w_data[rx_status_pkg::CONFIG_W-1:0];
		if (mode_detect_valid_in)
		begin
			case (mode_detect_code_in)
				rx_status_pkg::MODE_TYPE_A:
					next_config[rx_status_pkg::CRC_INVERT_BIT] = 1'b0;
				rx_status_pkg::MODE_TYPE_B:
				begin
					next_config[rx_status_pkg::CRC_INVERT_BIT] = 1'b1;
					next_config[rx_status_pkg::CRC_ENABLE_BIT] = 1'b1;
				end
				rx_status_pkg::MODE_JIS:
				begin
					next_config[rx_status_pkg::CRC_INVERT_BIT] = 1'b0;
					next_config[rx_status_pkg::CRC_ENABLE_BIT] = 1'b1;
				end
				default: ;
			endcase
		end
	end

	always_ff @(posedge clk_in)
	begin
		if (rst_in)
			config_q <= rx_status_pkg::CONFIG_RESET;
		else
			config_q <= next_config;
	end

	// ==========================================================
	// Receive frame tracking and status
	rx_status_pkg::rx_state_t state, next_state;
	logic [8:0]  bytes, next_bytes;
	logic [3:0]  frames, next_frames;
	logic [2:0]  last_bits, next_last_bits;
	logic        integrity, next_integrity;
	logic        protocol, next_protocol;
	logic        collision, next_collision;
	logic [6:0]  coll_pos, next_coll_pos;
	logic        coll_ok, next_coll_ok;
	logic        done, next_done;
	logic        take_byte, crc_bad, proto_hit;
	logic [11:0] pos_wide;
	logic [15:0] crc16;
	logic [4:0]  crc5;

	assign take_byte = (state == rx_status_pkg::ST_RECV) && rx_byte_valid_in;
	assign proto_hit = rx_stop_bit_error_in || rx_sof_eof_error_in
		|| rx_length_error_in || (take_byte && bytes == 9'h1FF);
	assign crc_bad = crc_type ? (crc5 != rx_status_pkg::CRC5_RESIDUE)
		: (crc16 != (crc_invert ? rx_status_pkg::CRC16_RESIDUE_INV
		: rx_status_pkg::CRC16_RESIDUE));
	assign pos_wide = {bytes, 3'b000} + 12'(rx_collision_bit_in)
		+ 12'(rx_align);
	assign rx_accept_out = (state == rx_status_pkg::ST_RECV);
	assign receive_done_interrupt_out = done;
	assign collision_position_valid_out = collision && coll_ok;
	assign status_word = {6'h00, coll_pos, collision, protocol, integrity,
		last_bits, frames, bytes};

	crc_check u_crc
	(
		.clk_in        (clk_in),
		.rst_in        (rst_in),
		.init_in       (rx_sof_in),
		.invert_in     (crc_invert),
		.byte_valid_in (take_byte),
		.byte_in       (rx_byte_in),
		.crc16_out     (crc16),
		.crc5_out      (crc5)
	);

	always_comb
	begin
		next_state     = state;
		next_bytes     = bytes;
		next_frames    = frames;
		next_last_bits = last_bits;
		next_integrity = integrity;
		next_protocol  = protocol;
		next_collision = collision;
		next_coll_pos  = coll_pos;
		next_coll_ok   = coll_ok;
		next_done      = 1'b0;
		if (rx_enable_in)
		begin
			next_state  = rx_status_pkg::ST_IDLE;
			next_bytes  = 9'h000;
			next_frames = 4'h0;
		end
		else if (rx_sof_in)
		begin
			next_state     = rx_status_pkg::ST_RECV;
			next_integrity = 1'b0;
			next_protocol  = 1'b0;
			next_collision = 1'b0;
			next_coll_pos  = 7'h00;
			next_coll_ok   = 1'b0;
		end
		else
		begin
			case (state)
				rx_status_pkg::ST_RECV:
				begin
					// Integrity errors do not leave this state
					if (take_byte)
						next_bytes = bytes + 9'h001;
					if (take_byte && rx_parity_error_in && !parity_stop)
						next_integrity = 1'b1;
					if (rx_collision_in && !collision)
					begin
						next_collision = 1'b1;
						next_coll_pos  = pos_wide[6:0];
						next_coll_ok   = (pos_wide[11:7] == 5'h00);
					end
					if (proto_hit)
					begin
						next_protocol = 1'b1;
						next_state    = rx_status_pkg::ST_HALT;
					end
					else if (rx_end_in)
					begin
						if (crc_enable && crc_bad)
							next_integrity = 1'b1;
						next_last_bits = rx_last_bits_in;
					end
				end
				rx_status_pkg::ST_HALT: ;
				default: next_state = rx_status_pkg::ST_IDLE;
			endcase
			if (rx_end_in && state != rx_status_pkg::ST_IDLE)
			begin
				next_state = rx_status_pkg::ST_IDLE;
				next_done  = 1'b1;
				if (multi_frame_enable)
					next_frames = frames + 4'h1;
			end
		end
	end

	always_ff @(posedge clk_in)
	begin
		if (rst_in)
		begin
			state     <= rx_status_pkg::ST_IDLE;
			bytes     <= 9'h000;
			frames    <= 4'h0;
			last_bits <= 3'h0;
			integrity <= 1'b0;
			protocol  <= 1'b0;
			collision <= 1'b0;
			coll_pos  <= 7'h00;
			coll_ok   <= 1'b0;
			done      <= 1'b0;
		end
		else
		begin
			state     <= next_state;
			bytes     <= next_bytes;
			frames    <= next_frames;
			last_bits <= next_last_bits;
			integrity <= next_integrity;
			protocol  <= next_protocol;
			collision <= next_collision;
			coll_pos  <= next_coll_pos;
			coll_ok   <= next_coll_ok;
			done      <= next_done;
		end
	end

	// ==========================================================
	// Checks
	AST_TYPE_B_MODE: assert property (@(posedge clk_in) disable iff (rst_in)
		mode_detect_valid_in && mode_detect_code_in == 2'h2
		|=> crc_invert && crc_enable)
		else $error("type B detection did not set invert and enable");

	AST_JIS_MODE: assert property (@(posedge clk_in) disable iff (rst_in)
		mode_detect_valid_in && mode_detect_code_in == 2'h3
		|=> crc_enable && !crc_invert)
		else $error("JIS detection did not set enable");

	AST_TYPE_A_MODE: assert property (@(posedge clk_in) disable iff (rst_in)
		mode_detect_valid_in && mode_detect_code_in == 2'h1 |=> !crc_invert)
		else $error("type A detection did not clear invert");

	AST_PROTO_HALT: assert property (@(posedge clk_in) disable iff (rst_in)
		$rose(protocol) |-> !rx_accept_out
		throughout (1'b1 ##1 1'b1))
		else $error("receiver still accepting after protocol error");

	AST_SOF_CLEAR: assert property (@(posedge clk_in) disable iff (rst_in)
		rx_sof_in && !rx_enable_in |=> !protocol && !integrity && !collision)
		else $error("error flags not cleared at reception start");

	AST_FIRST_COLL: assert property (@(posedge clk_in) disable iff (rst_in)
		collision && !rx_sof_in && !rx_enable_in |=> $stable(coll_pos))
		else $error("collision position overwritten");

	AST_COLL_FLAG: assert property (@(posedge clk_in) disable iff (rst_in)
		rx_collision_in && state == rx_status_pkg::ST_RECV
		&& !rx_sof_in && !rx_enable_in |=> collision)
		else $error("collision flag not set");

	AST_PARITY: assert property (@(posedge clk_in) disable iff (rst_in)
		take_byte && rx_parity_error_in && !rx_sof_in && !rx_enable_in
		&& !rx_end_in |=> integrity == !$past(parity_stop) || $past(integrity))
		else $error("parity error handling wrong");

	AST_FRAMES: assert property (@(posedge clk_in) disable iff (rst_in)
		rx_end_in && state != rx_status_pkg::ST_IDLE && multi_frame_enable
		&& !rx_sof_in && !rx_enable_in
		|=> frames == $past(frames) + 4'h1 && receive_done_interrupt_out)
		else $error("frame count not advanced with done event");

	AST_BYTES: assert property (@(posedge clk_in) disable iff (rst_in)
		take_byte && integrity && !rx_sof_in && !rx_enable_in && !proto_hit
		|=> bytes == $past(bytes) + 9'h001)
		else $error("bytes stopped after integrity error");

	AST_RESERVED: assert property (@(posedge clk_in) disable iff (rst_in)
		s_axi_arvalid_in && s_axi_arready_out
		&& reg_select(s_axi_araddr_in) == 2'h2 |=> rdata[31:26] == 6'h00)
		else $error("reserved status bits not zero");

endmodule

// *** card_model.sv ***
`timescale 1ns/100ps

module card_model
(
	input  wire logic clk_in,
	output logic       sof_out,
	output logic       byte_valid_out,
	output logic [7:0] byte_out,
	output logic       parity_error_out,
	output logic       collision_out,
	output logic [2:0] collision_bit_out,
	output logic [2:0] fault_out,
	output logic       end_out,
	output logic [2:0] last_bits_out
);
	// ==========================================================
	// Card side of the air link, one event per clock
	initial
	begin
		{sof_out, byte_valid_out, byte_out, parity_error_out} = '0;
		{collision_out, collision_bit_out, fault_out} = '0;
		{end_out, last_bits_out} = '0;
	end

	task automatic start();
		sof_out <= 1'b1;
		@(posedge clk_in);
		sof_out <= 1'b0;
	endtask

	// Unqualified data lines show the inverse of the last value
	task automatic send(input logic [7:0] q[$], input int perr);
		foreach (q[i])
		begin
			byte_valid_out   <= 1'b1;
			byte_out         <= q[i];
			parity_error_out <= (i == perr);
			@(posedge clk_in);
		end
		byte_valid_out   <= 1'b0;
		byte_out         <= ~byte_out;
		parity_error_out <= 1'b0;
	endtask

	task automatic clash(input logic [2:0] n);
		collision_out     <= 1'b1;
		collision_bit_out <= n;
		@(posedge clk_in);
		collision_out     <= 1'b0;
		collision_bit_out <= ~n;
	endtask

	task automatic fault(input int k);
		fault_out[k] <= 1'b1;
		@(posedge clk_in);
		fault_out <= '0;
	endtask

	task automatic finish(input logic [2:0] lb);
		end_out       <= 1'b1;
		last_bits_out <= lb;
		@(posedge clk_in);
		end_out       <= 1'b0;
		last_bits_out <= ~lb;
	endtask
endmodule

// *** tb_top.sv ***
`timescale 1ns/100ps

module tb_top;
	localparam logic [7:0] CF_A = {rx_status_pkg::CONFIG_INDEX[5:0], 2'h0};
	localparam logic [7:0] ST_A = {rx_status_pkg::STATUS_INDEX[5:0], 2'h0};
	localparam logic [1:0] OK = rx_status_pkg::RESP_OKAY;
	localparam logic [1:0] DE = rx_status_pkg::RESP_DECERR;
	localparam logic [7:0] CFGS [5] = '{8'h03, 8'h03, 8'h01, 8'h01, 8'h00};
	localparam logic [4:0] BAD = 5'h1A;
	localparam logic [4:0] IE = 5'h0A;
	localparam int LIMIT = 20000;

	logic        clk_in = 1'b0;
	logic        rst_in = 1'b1;
	logic [7:0]  awaddr = 8'h00;
	logic        awvalid = 1'b0;
	logic [31:0] wdata = 32'h0;
	logic [3:0]  wstrb = 4'hF;
	logic        wvalid = 1'b0;
	logic        bready = 1'b1;
	logic [7:0]  araddr = 8'h00;
	logic        arvalid = 1'b0;
	logic        rready = 1'b1;
	logic        md_valid = 1'b0;
	logic [1:0]  md_code = 2'h0;
	logic        rx_en = 1'b0;
	logic        awready, wready, bvalid, arready, rvalid;
	logic [1:0]  bresp, rresp;
	logic [31:0] rdata;
	logic        accept, done, cpv, mfr, sof, bv, par, coll, fin;
	logic [7:0]  rxb;
	logic [2:0]  cbit, flt, lbits;
	logic [31:0] seed = 32'hB0BE;
	int          num_errors = 0;
	int          checks = 0;
	int          cycles = 0;

	always #20 clk_in = ~clk_in;

	rx_decoder_crc_status DUT
	(
		.clk_in(clk_in), .rst_in(rst_in),
		.s_axi_awaddr_in(awaddr), .s_axi_awvalid_in(awvalid),
		.s_axi_awready_out(awready), .s_axi_wdata_in(wdata),
		.s_axi_wstrb_in(wstrb), .s_axi_wvalid_in(wvalid),
		.s_axi_wready_out(wready), .s_axi_bresp_out(bresp),
		.s_axi_bvalid_out(bvalid), .s_axi_bready_in(bready),
		.s_axi_araddr_in(araddr), .s_axi_arvalid_in(arvalid),
		.s_axi_arready_out(arready), .s_axi_rdata_out(rdata),
		.s_axi_rresp_out(rresp), .s_axi_rvalid_out(rvalid),
		.s_axi_rready_in(rready), .mode_detect_valid_in(md_valid),
		.mode_detect_code_in(md_code), .rx_enable_in(rx_en),
		.rx_sof_in(sof), .rx_byte_valid_in(bv), .rx_byte_in(rxb),
		.rx_parity_error_in(par), .rx_collision_in(coll),
		.rx_collision_bit_in(cbit), .rx_stop_bit_error_in(flt[0]),
		.rx_sof_eof_error_in(flt[1]), .rx_length_error_in(flt[2]),
		.rx_end_in(fin), .rx_last_bits_in(lbits),
		.rx_accept_out(accept), .receive_done_interrupt_out(done),
		.collision_position_valid_out(cpv),
		.multi_frame_reception_out(mfr)
	);

	card_model card
	(
		.clk_in(clk_in), .sof_out(sof), .byte_valid_out(bv),
		.byte_out(rxb), .parity_error_out(par), .collision_out(coll),
		.collision_bit_out(cbit), .fault_out(flt), .end_out(fin),
		.last_bits_out(lbits)
	);

	// ==========================================================
	// Expectation helpers
	function automatic logic [7:0] rnd();
		repeat (8) seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
		return seed[7:0];
	endfunction

	function automatic logic [15:0] crc16(logic [7:0] q[$], logic [15:0] c);
		foreach (q[i])
		begin
			c = c ^ {8'h00, q[i]};
			for (int k = 0; k < 8; k++)
				c = c[0] ? (c >> 1) ^ rx_status_pkg::CRC16_POLY : c >> 1;
		end
		return c;
	endfunction

	function automatic logic [31:0] stat(int p, int f, int lb, int fr, int nb);
		return 32'(p) << rx_status_pkg::COLL_POS_LSB
			| 32'(f) << rx_status_pkg::INTEGRITY_BIT
			| 32'(lb) << rx_status_pkg::LAST_BITS_LSB
			| 32'(fr) << rx_status_pkg::FRAMES_LSB | 32'(nb);
	endfunction

	// ==========================================================
	// Bus and link tasks
	task automatic chk(string what, logic [31:0] exp, logic [31:0] got);
		checks++;
		if (got !== exp)
		begin
			num_errors++;
			$display("[ERR] %s expected %h seen %h", what, exp, got);
		end
	endtask

	task automatic axi_wr(logic [7:0] a, logic [31:0] d, logic [1:0] er);
		logic ta, tw, pa, pw;
		pa = 1'b1;
		pw = 1'b1;
		awaddr  <= a;
		wdata   <= d;
		awvalid <= 1'b1;
		wvalid  <= 1'b1;
		while (pa || pw)
		begin
			@(negedge clk_in);
			ta = pa && awready;
			tw = pw && wready;
			@(posedge clk_in);
			if (ta)
				awvalid <= 1'b0;
			if (tw)
				wvalid <= 1'b0;
			pa = pa && !ta;
			pw = pw && !tw;
		end
		do @(negedge clk_in); while (!bvalid);
		chk("bresp", 32'(er), 32'(bresp));
		@(posedge clk_in);
	endtask

	task automatic rchk(string w, logic [7:0] a, logic [31:0] e,
		logic [31:0] m, logic [1:0] er);
		logic t;
		araddr  <= a;
		arvalid <= 1'b1;
		do
		begin
			@(negedge clk_in);
			t = arready;
			@(posedge clk_in);
		end
		while (!t);
		arvalid <= 1'b0;
		do @(negedge clk_in); while (!rvalid);
		chk(w, e, rdata & m);
		chk("rresp", 32'(er), 32'(rresp));
		@(posedge clk_in);
	endtask

	task automatic mode(logic [1:0] c);
		md_valid <= 1'b1;
		md_code  <= c;
		@(posedge clk_in);
		md_valid <= 1'b0;
		md_code  <= ~c;
	endtask

	task automatic enable();
		rx_en <= 1'b1;
		@(posedge clk_in);
		rx_en <= 1'b0;
	endtask

	task automatic bytes(int n, int perr);
		logic [7:0] q[$];
		repeat (n) q.push_back(rnd());
		card.send(q, perr);
	endtask

	task automatic end_frame(logic [2:0] lb);
		card.finish(lb);
		@(negedge clk_in);
		chk("done", 1, 32'(done));
		@(negedge clk_in);
		chk("done drop", 0, 32'(done));
		@(posedge clk_in);
	endtask

	task automatic frame(int n, logic inv, logic bad, logic [2:0] lb);
		logic [7:0]  q[$];
		logic [15:0] c;
		repeat (n) q.push_back(rnd());
		c = crc16(q, inv ? rx_status_pkg::CRC16_PRESET_INV
			: rx_status_pkg::CRC16_PRESET_NORM);
		c = (inv ? ~c : c) ^ {15'h0, bad};
		q.push_back(c[7:0]);
		q.push_back(c[15:8]);
		card.start();
		card.send(q, -1);
		end_frame(lb);
	endtask

	// 5-bit check value rides in the low bits of one trailing byte
	task automatic frame5(int n, logic bad);
		logic [7:0] q[$];
		logic [4:0] c;
		repeat (n) q.push_back(rnd());
		c = rx_status_pkg::CRC5_PRESET;
		foreach (q[i])
			for (int k = 0; k < 8; k++)
				c = (c[0] ^ q[i][k]) ? (c >> 1) ^ rx_status_pkg::CRC5_POLY
					: c >> 1;
		q.push_back({3'h0, c ^ {4'h0, bad}});
		card.start();
		card.send(q, -1);
		end_frame(0);
	endtask

	task automatic results();
		$display("checks %0d errors %0d", checks, num_errors);
		if (num_errors == 0 && checks > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask

	always @(posedge clk_in)
	begin
		cycles++;
		if (cycles == LIMIT)
		begin
			num_errors++;
			results();
		end
	end

	// ==========================================================
	// Scenarios
	initial
	begin
		int n;
		int lb;
		repeat (16) @(posedge clk_in);
		rst_in <= 1'b0;
		@(posedge clk_in);
		rchk("status", ST_A, 0, '1, OK);
		rchk("config", CF_A, 0, '1, OK);
		rchk("unmapped", 8'h50, 0, '1, DE);
		axi_wr(ST_A, '1, OK);
		rchk("status ro", ST_A, 0, '1, OK);
		axi_wr(CF_A, '1, OK);
		rchk("config all", CF_A, 32'hFF, '1, OK);
		axi_wr(CF_A, 0, OK);
		mode(rx_status_pkg::MODE_TYPE_B);
		rchk("mode b", CF_A, 32'h3, '1, OK);
		mode(rx_status_pkg::MODE_TYPE_A);
		rchk("mode a", CF_A, 32'h1, '1, OK);
		axi_wr(CF_A, 0, OK);
		mode(rx_status_pkg::MODE_JIS);
		rchk("mode jis", CF_A, 32'h1, '1, OK);
		for (int i = 0; i < 5; i++)
		begin
			axi_wr(CF_A, 32'(CFGS[i]), OK);
			enable();
			n = 1 + rnd() % 8;
			lb = rnd() % 8;
			frame(n, CFGS[i][1], BAD[i], 3'(lb));
			rchk("crc", ST_A, stat(0, IE[i], lb, 0, n + 2), '1, OK);
		end
		for (int i = 0; i < 2; i++)
		begin
			axi_wr(CF_A, 32'h05, OK);
			enable();
			frame5(3, i);
			rchk("crc5", ST_A, stat(0, i, 0, 0, 4), '1, OK);
		end
		for (int j = 0; j < 2; j++)
		begin
			axi_wr(CF_A, j ? 32'h80 : 32'h0, OK);
			enable();
			card.start();
			bytes(4, 1);
			@(negedge clk_in);
			chk("accept", 1, 32'(accept));
			@(posedge clk_in);
			end_frame(0);
			rchk("parity", ST_A, stat(0, !j, 0, 0, 4), '1, OK);
		end
		axi_wr(CF_A, 32'h30, OK);
		enable();
		card.start();
		bytes(2, -1);
		card.clash(5);
		bytes(1, -1);
		card.clash(1);
		bytes(1, -1);
		end_frame(5);
		chk("coll valid", 1, 32'(cpv));
		rchk("coll", ST_A, stat(24, 4, 5, 0, 4), '1, OK);
		axi_wr(CF_A, 0, OK);
		for (int k = 0; k < 3; k++)
		begin
			enable();
			card.start();
			bytes(1, -1);
			card.fault(k);
			@(negedge clk_in);
			chk("halt", 0, 32'(accept));
			@(posedge clk_in);
			bytes(1, -1);
			card.finish(0);
			// Halted frames keep the last-bits value of the collision frame
			rchk("proto", ST_A, stat(0, 2, 5, 0, 1), '1, OK);
		end
		card.start();
		rchk("proto clr", ST_A, 0, 32'h30000, OK);
		end_frame(0);
		axi_wr(CF_A, 32'h08, OK);
		chk("multi", 1, 32'(mfr));
		enable();
		for (int f = 1; f < 4; f++)
		begin
			frame(1 + rnd() % 8, 0, 0, 0);
			rchk("frames", ST_A, stat(0, 0, 0, f, 0), 32'h1E00, OK);
		end
		enable();
		rchk("counts clr", ST_A, 0, '1, OK);
		results();
	end
endmodule
